// ---- bench/dual_mode_serial_eeprom_port_bench.sv ----
module dual_mode_serial_eeprom_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WCYC = 1000; // Short program time keeps the run small.
    localparam int LIMIT = 40000; // The sequence needs about 20000 cycles.
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic scl, tclk, pull, sda_o, sda_oe, bidir, busy;
    int mem [128];
    int seed = 73999;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int tx_a = 0;
    int rd_a = 0;

    // Open-drain data wire with a pull-up.
    wire logic sda = (sda_oe ? sda_o : 1'b1) & ~pull;

    // Device with a short program time, and the host on the far side.
    dual_mode_serial_eeprom_port #(.WRITE_CYCLES(WCYC)) dual_mode_serial_eeprom_port_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
        .transmit_only_clock_in(tclk), .sda_in(sda), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .bidir_mode_out(bidir), .write_busy_out(busy));
    host_model host_model_inst (.clk_in(core_clk_in), .sda_in(sda), .scl_out(scl),
        .tclk_out(tclk), .pull_out(pull));

    // Core clock of 8 ns.
    always #4 core_clk_in = ~core_clk_in;

    // Cuts a hung run short.
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            print_verdict();
        end
    end

    // Compares single levels and whole bytes.
    task automatic chk_lvl(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    // Looks at the status outputs between clock edges.
    task automatic flags(input logic eb, input logic ey);
        @(negedge core_clk_in);
        chk_lvl("bidir_mode", eb, bidir);
        chk_lvl("write_busy", ey, busy);
        @(posedge core_clk_in);
    endtask

    // Transmit-only clock rises during which SDA must stay released.
    task automatic rel_rises(input int n);
        logic s;
        for (int i = 0; i < n; i++) begin
            host_model_inst.tclk_rise(s);
            chk_lvl("released_sda", 1'b1, s);
        end
    endtask

    // Checks bytes of the stream, MSB first and a released null bit, against the model.
    task automatic tx_stream(input int nb);
        logic s;
        int b;
        for (int i = 0; i < nb * 9; i++) begin
            host_model_inst.tclk_rise(s);
            b = (i % 9 == 8) ? 1 : (mem[(tx_a + i / 9) % 128] >> (7 - i % 9)) & 1;
            chk_lvl("tx_sda", 1'(b), s);
        end
        tx_a = tx_a + nb;
    endtask

    // Waits, bounded, for the program cycle to end.
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy === 1'b1 && k < 2 * WCYC) begin
            @(posedge core_clk_in);
            k++;
        end
        flags(1'b1, 1'b0);
    endtask

    // Byte write; a protected one drops the write-enable level in mid-transfer.
    task automatic write_one(input int ad, input logic [7:0] d, input logic prot);
        logic a;
        host_model_inst.cond(1'b0);
        host_model_inst.byte_w(8'hA0, a);
        host_model_inst.byte_w(8'(ad), a);
        chk_lvl("waddr_ack", 1'b1, a);
        if (prot) begin
            host_model_inst.set_tclk(1'b0);
            host_model_inst.set_tclk(1'b1);
        end else begin
            mem[ad] = d;
        end
        host_model_inst.byte_w(d, a);
        chk_lvl("wdata_ack", 1'b1, a);
        host_model_inst.cond(1'b1);
        flags(1'b1, ~prot);
        wait_idle();
    endtask

    // Read of n bytes; a negative address reads from the current pointer.
    task automatic read_chk(input int ad, input int n);
        logic a;
        logic r;
        logic [7:0] d;
        if (ad >= 0) begin
            host_model_inst.cond(1'b0);
            host_model_inst.byte_w(8'hA0, a);
            host_model_inst.byte_w(8'(ad), a);
            rd_a = ad;
        end
        host_model_inst.cond(1'b0);
        host_model_inst.byte_w(8'hA1, a);
        chk_lvl("rctl_ack", 1'b1, a);
        for (int k = 0; k < n; k++) begin
            host_model_inst.byte_r(k < n - 1, d, r);
            chk_byte("rd_data", 8'(mem[rd_a]), d);
            rd_a = (rd_a + 1) % 128;
        end
        chk_lvl("nack_sda", 1'b1, r);
        host_model_inst.cond(1'b1);
    endtask

    // Main sequence.
    initial begin
        logic a;
        logic [7:0] d;
        repeat (10) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        rel_rises(9);
        tx_stream(2);
        done("startup_stream");
        host_model_inst.scl_pulse();
        rel_rises(100);
        host_model_inst.scl_pulse();
        rel_rises(128);
        tx_a = 0;
        tx_stream(2);
        flags(1'b0, 1'b0);
        done("fallback");
        // Page write of ten bytes from word address 85h, then a poll while busy.
        host_model_inst.cond(1'b0);
        host_model_inst.byte_w(8'hA0, a);
        chk_lvl("ctrl_ack", 1'b1, a);
        host_model_inst.byte_w(8'h85, a);
        chk_lvl("addr_ack", 1'b1, a);
        for (int i = 0; i < 10; i++) begin
            d = 8'($random(seed));
            mem[(5 + i) % 8] = d;
            host_model_inst.byte_w(d, a);
            chk_lvl("data_ack", 1'b1, a);
        end
        host_model_inst.cond(1'b1);
        flags(1'b1, 1'b1);
        host_model_inst.set_tclk(1'b0);
        host_model_inst.cond(1'b0);
        host_model_inst.byte_w(8'hA0, a);
        chk_lvl("busy_ack", 1'b0, a);
        host_model_inst.cond(1'b1);
        host_model_inst.set_tclk(1'b1);
        wait_idle();
        done("page_write");
        // A foreign address, then clock pulses that must be ignored.
        d = 8'($random(seed));
        d[7:1] = d[7:1] ^ ((d[7:1] == 7'h50) ? 7'h01 : 7'h00);
        host_model_inst.cond(1'b0);
        host_model_inst.byte_w(d, a);
        chk_lvl("foreign_ack", 1'b0, a);
        host_model_inst.cond(1'b1);
        rel_rises(9);
        flags(1'b1, 1'b0);
        done("foreign_and_ignored_clock");
        read_chk(0, 16);
        read_chk(126, 4);
        read_chk(-1, 2);
        done("reads");
        write_one(32, 8'($random(seed)), 1'b1);
        write_one(32 + ($random(seed) & 7), 8'($random(seed)), 1'b0);
        read_chk(31, 10);
        done("byte_writes");
        print_verdict();
    end
endmodule // dual_mode_serial_eeprom_port_bench

// ---- bench/host_model.sv ----
module host_model (
    // Clock of the bench.
    input wire logic clk_in,
    // Resolved data wire.
    input wire logic sda_in,
    // Host-driven pins.
    output logic scl_out,
    output logic tclk_out,
    output logic pull_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 8; // Core cycles per third of a bit, well past the pin filter.

    // Idle bus: both clocks high and data released.
    initial begin
        scl_out = 1'b1;
        tclk_out = 1'b1;
        pull_out = 1'b0;
    end

    // Waits a number of core clock edges.
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Takes the wire level late in a high phase and ends on a clock edge.
    task automatic look(output logic s);
        hold(Q - 1);
        #1 s = sda_in;
        hold(1);
    endtask

    // One transmit-only clock period; the clock stands high between uses.
    task automatic tclk_rise(output logic s);
        tclk_out <= 1'b0;
        hold(Q);
        tclk_out <= 1'b1;
        look(s);
    endtask

    // Moves the write-enable level.
    task automatic set_tclk(input logic v);
        tclk_out <= v;
        hold(Q);
    endtask

    // One SCL pulse with SDA left alone.
    task automatic scl_pulse();
        scl_out <= 1'b0;
        hold(Q);
        scl_out <= 1'b1;
        hold(Q);
    endtask

    // One bit; data moves only while SCL is low.
    task automatic bit_c(input logic b, output logic s);
        scl_out <= 1'b0;
        hold(Q);
        pull_out <= ~b;
        hold(Q);
        scl_out <= 1'b1;
        look(s);
    endtask

    // Start or stop: SDA moves while SCL is high.
    task automatic cond(input logic is_stop);
        scl_out <= 1'b0;
        hold(Q);
        pull_out <= is_stop;
        hold(Q);
        scl_out <= 1'b1;
        hold(Q);
        pull_out <= ~is_stop;
        hold(Q);
    endtask

    // Sends a byte and supplies the ninth clock for the acknowledge.
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], s);
        end
        bit_c(1'b1, s);
        ack = ~s;
    endtask

    // Reads a byte; a withheld acknowledge ends the read.
    task automatic byte_r(input logic more, output logic [7:0] d, output logic rel);
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, d[i]);
        end
        bit_c(~more, rel);
    endtask
endmodule // host_model

// ---- verilog/dual_mode_serial_eeprom_port.sv ----
module dual_mode_serial_eeprom_port
    import eeprom_port_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Serial pins.
    input wire logic scl_in,
    input wire logic transmit_only_clock_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Status.
    output logic bidir_mode_out,
    output logic write_busy_out
);

    typedef struct packed {
        mode_t mode;
        logic [3:0] init_cnt;
        logic [3:0] tx_bit;
        logic [ADDR_W-1:0] tx_addr;
        logic [7:0] pulse_cnt;
        slave_st_t ist;
        slave_st_t ack_next;
        logic [2:0] bit_cnt;
        logic byte_done;
        logic mack;
        logic [7:0] shift;
        logic [ADDR_W-1:0] ptr;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic [PAGE_BYTES-1:0] pvalid;
        logic pend;
        logic we_ok;
        logic [BUSY_W-1:0] busy_cnt;
        logic sda_oe;
        logic bidir;
        logic busy;
        logic [ARR_DEPTH-1:0][7:0] mem;
    } port_t;

    port_t r;
    port_t n;

    logic [2:0] pins;
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] fall;
    logic scl_rise;
    logic scl_fall;
    logic transmit_only_clock_rise;
    logic transmit_only_clock_lvl;
    logic sda_lvl;
    logic start_evt;
    logic stop_evt;
    logic busy_now;
    logic dev_match;

    // Every pin is filtered in the core clock domain.
    assign pins = {transmit_only_clock_in, sda_in, scl_in};
    for (genvar g = 0; g < 3; g++) begin : g_pin
        pin_filter u_filt (
            .clk_in(core_clk_in),
            .rst_n_in(rst_n_in),
            .pin_in(pins[g]),
            .level_out(lvl[g]),
            .rise_out(rise[g]),
            .fall_out(fall[g])
        );
    end

    // Bus conditions decoded from the filtered lines.
    assign scl_rise = rise[0];
    assign scl_fall = fall[0];
    assign sda_lvl = lvl[1];
    assign transmit_only_clock_lvl = lvl[2];
    assign transmit_only_clock_rise = rise[2];
    assign start_evt = fall[1] & lvl[0];
    assign stop_evt = rise[1] & lvl[0];
    assign busy_now = (r.busy_cnt != '0);
    assign dev_match = (r.shift[7:1] == DEV_CODE);

    // Mode control, transmit-only stream and the bidirectional slave.
    always_comb begin
        n = r;
        if (busy_now) begin
            n.busy_cnt = r.busy_cnt - 1'b1;
        end
        case (r.mode)
            MODE_TX: begin
                if (scl_fall) begin
                    n.mode = MODE_TRANS;
                    n.pulse_cnt = '0;
                    n.sda_oe = 1'b0;
                end else if (transmit_only_clock_rise) begin
                    if (r.init_cnt != INIT_CYCLES) begin
                        n.init_cnt = r.init_cnt + 4'h1;
                        n.sda_oe = 1'b0;
                    end else if (r.tx_bit == FRAME_LAST) begin
                        n.sda_oe = 1'b0;
                        n.tx_bit = 4'h0;
                        n.tx_addr = r.tx_addr + 7'h01;
                    end else begin
                        n.sda_oe = ~r.mem[r.tx_addr][3'h7 - r.tx_bit[2:0]];
                        n.tx_bit = r.tx_bit + 4'h1;
                    end
                end
            end
            MODE_TRANS: begin
                if (scl_fall) begin
                    n.pulse_cnt = '0;
                end else if (transmit_only_clock_rise) begin
                    if (r.pulse_cnt + 8'h01 == FALLBACK_PULSES) begin
                        n.mode = MODE_TX;
                        n.tx_addr = TX_START_ADDR;
                        n.tx_bit = 4'h0;
                        n.ist = I_IDLE;
                        n.sda_oe = 1'b0;
                    end else begin
                        n.pulse_cnt = r.pulse_cnt + 8'h01;
                    end
                end
            end
            default: begin
                // Bidirectional mode ignores transmit-only clock edges; SCL edges still drive the slave engine.
            end
        endcase
        // Slave engine runs in transition and bidirectional modes.
        if (r.mode != MODE_TX) begin
            if (start_evt) begin
                n.ist = I_DEV;
                n.bit_cnt = 3'h0;
                n.byte_done = 1'b0;
                n.sda_oe = 1'b0;
                n.pend = 1'b0;
                n.pvalid = '0;
                n.we_ok = transmit_only_clock_lvl;
            end else if (stop_evt) begin
                n.ist = I_IDLE;
                n.sda_oe = 1'b0;
                n.pend = 1'b0;
                n.pvalid = '0;
                if (r.pend && r.we_ok && !busy_now) begin
                    for (int i = 0; i < PAGE_BYTES; i++) begin
                        if (r.pvalid[i]) begin
                            n.mem[{r.ptr[6:3], 3'(i)}] = r.pbuf[i];
                        end
                    end
                    n.busy_cnt = BUSY_W'(WRITE_CYCLES);
                end
            end else begin
                if (r.ist != I_IDLE && !transmit_only_clock_lvl) begin
                    n.we_ok = 1'b0;
                end
                if (scl_rise) begin
                    case (r.ist)
                        I_DEV, I_WADDR, I_WDATA: begin
                            n.shift = {r.shift[6:0], sda_lvl};
                            n.bit_cnt = r.bit_cnt + 3'h1;
                            n.byte_done = (r.bit_cnt == 3'h7);
                        end
                        I_RDATA: begin
                            n.bit_cnt = r.bit_cnt + 3'h1;
                            n.byte_done = (r.bit_cnt == 3'h7);
                        end
                        I_RACK: begin
                            n.mack = ~sda_lvl;
                        end
                        default: begin
                        end
                    endcase
                end
                if (scl_fall) begin
                    case (r.ist)
                        I_DEV: begin
                            if (r.byte_done) begin
                                n.byte_done = 1'b0;
                                n.ist = I_IDLE;
                                if (dev_match) begin
                                    n.mode = MODE_BIDIR;
                                    if (!busy_now) begin
                                        n.sda_oe = 1'b1;
                                        n.ist = I_ACK;
                                        n.ack_next = r.shift[0] ? I_RDATA : I_WADDR;
                                    end
                                end
                            end
                        end
                        I_WADDR: begin
                            if (r.byte_done) begin
                                n.byte_done = 1'b0;
                                n.ptr = r.shift[6:0];
                                n.sda_oe = 1'b1;
                                n.ist = I_ACK;
                                n.ack_next = I_WDATA;
                            end
                        end
                        I_WDATA: begin
                            if (r.byte_done) begin
                                n.byte_done = 1'b0;
                                n.pbuf[r.ptr[2:0]] = r.shift;
                                n.pvalid[r.ptr[2:0]] = 1'b1;
                                n.pend = 1'b1;
                                n.ptr = {r.ptr[6:3], r.ptr[2:0] + 3'h1};
                                n.sda_oe = 1'b1;
                                n.ist = I_ACK;
                                n.ack_next = I_WDATA;
                            end
                        end
                        I_ACK: begin
                            n.sda_oe = 1'b0;
                            n.ist = r.ack_next;
                            n.bit_cnt = 3'h0;
                            if (r.ack_next == I_RDATA) begin
                                n.shift = r.mem[r.ptr];
                                n.sda_oe = ~r.mem[r.ptr][7];
                                n.ptr = r.ptr + 7'h01;
                            end
                        end
                        I_RDATA: begin
                            if (r.byte_done) begin
                                n.byte_done = 1'b0;
                                n.sda_oe = 1'b0;
                                n.ist = I_RACK;
                            end else begin
                                n.shift = {r.shift[6:0], 1'b0};
                                n.sda_oe = ~r.shift[6];
                            end
                        end
                        I_RACK: begin
                            n.bit_cnt = 3'h0;
                            if (r.mack) begin
                                n.shift = r.mem[r.ptr];
                                n.sda_oe = ~r.mem[r.ptr][7];
                                n.ptr = r.ptr + 7'h01;
                                n.ist = I_RDATA;
                            end else begin
                                n.ist = I_IDLE;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        n.bidir = (n.mode == MODE_BIDIR);
        n.busy = (n.busy_cnt != '0);
    end

    // State register; reset lands in transmit-only mode at location zero.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // The pin is open drain, so only a low level is ever driven.
    assign sda_out = 1'b0;
    assign sda_oe_out = r.sda_oe;
    assign bidir_mode_out = r.bidir;
    assign write_busy_out = r.busy;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_init_quiet;
        (r.mode == MODE_TX && r.init_cnt != INIT_CYCLES) |-> !sda_oe_out;
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("SDA driven during init");

    property p_first_bit;
        (r.mode == MODE_TX && transmit_only_clock_rise && !scl_fall && r.init_cnt == INIT_CYCLES
            && r.tx_bit == 4'h0 && r.tx_addr == 7'h00) |=> (sda_oe_out == ~$past(r.mem[0][7]));
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("First bit not MSB of 00h");

    property p_null_bit;
        (r.mode == MODE_TX && transmit_only_clock_rise && !scl_fall && r.init_cnt == INIT_CYCLES
            && r.tx_bit == FRAME_LAST) |=> !sda_oe_out && r.tx_bit == 4'h0;
    endproperty
    a_null_bit: assert property (p_null_bit) else $error("Null bit not released");

    property p_enter_trans;
        (r.mode == MODE_TX && scl_fall) |=> r.mode == MODE_TRANS && r.pulse_cnt == 8'h00;
    endproperty
    a_enter_trans: assert property (p_enter_trans) else $error("SCL fall missed");

    property p_count_clear;
        (r.mode == MODE_TRANS && scl_fall) |=> r.pulse_cnt == 8'h00;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("Pulse count kept");

    property p_fallback;
        (r.mode == MODE_TRANS && transmit_only_clock_rise && !scl_fall && !start_evt && !stop_evt
            && r.pulse_cnt == FALLBACK_PULSES - 8'h01)
            |=> r.mode == MODE_TX && r.tx_addr == 7'h00 && !sda_oe_out;
    endproperty
    a_fallback: assert property (p_fallback) else $error("No fallback at 128");

    property p_sticky;
        (r.mode == MODE_BIDIR) |=> (r.mode == MODE_BIDIR) [*4];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Left bidirectional mode");

    property p_other_addr;
        (r.mode != MODE_TX && r.ist == I_DEV && r.byte_done && scl_fall && !start_evt
            && !stop_evt && !dev_match) |=> r.ist == I_IDLE && !sda_oe_out;
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("Foreign address taken");

    property p_busy_quiet;
        busy_now |-> !sda_oe_out;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("ACK while programming");

    property p_addr_ack;
        (r.mode != MODE_TX && r.ist == I_DEV && r.byte_done && scl_fall && !start_evt
            && !stop_evt && dev_match && !busy_now) |=> sda_oe_out && r.ist == I_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Own address not acked");

    property p_protect;
        (r.mode != MODE_TX && stop_evt && !r.we_ok && !busy_now) |=> !busy_now;
    endproperty
    a_protect: assert property (p_protect) else $error("Write while protected");

    property p_busy_run;
        busy_now |=> r.busy_cnt == $past(r.busy_cnt) - 1'b1;
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("Program cycle stalled");

    property p_page_wrap;
        (r.mode != MODE_TX && r.ist == I_WDATA && r.byte_done && scl_fall && !start_evt
            && !stop_evt) |=> r.ptr[6:3] == $past(r.ptr[6:3])
            && r.ptr[2:0] == $past(r.ptr[2:0]) + 3'h1;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("Page pointer step wrong");

    c_fallback: cover property (r.mode == MODE_TRANS ##1 r.mode == MODE_TX);
    c_bidir: cover property (r.mode == MODE_TRANS ##1 r.mode == MODE_BIDIR);
    c_commit: cover property (!busy_now ##1 busy_now);
    c_read: cover property (r.ist == I_RDATA ##1 r.ist == I_RACK);

endmodule // dual_mode_serial_eeprom_port

// ---- verilog/eeprom_port_pkg.sv ----
package eeprom_port_pkg;

    // Array geometry and addressing.
    localparam int ARR_DEPTH = 128;
    localparam int ADDR_W = 7;
    localparam int PAGE_BYTES = 8;
    localparam logic [6:0] DEV_CODE = 7'h50;

    // Transmit-only framing and start-up.
    localparam logic [3:0] INIT_CYCLES = 4'h9;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [7:0] FALLBACK_PULSES = 8'h80;
    localparam logic [6:0] TX_START_ADDR = 7'h00;

    // Self-timed program cycle.
    localparam int WRITE_TIME_MS = 10;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WRITE_CYCLES_DFLT = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUSY_W = 21;

    // Idle level of the pins at reset.
    localparam logic PIN_IDLE = 1'b1;

    typedef enum logic [1:0] {MODE_TX, MODE_TRANS, MODE_BIDIR} mode_t;

    typedef enum logic [2:0] {
        I_IDLE, I_DEV, I_WADDR, I_WDATA, I_ACK, I_RDATA, I_RACK
    } slave_st_t;

endpackage

// ---- verilog/pin_filter.sv ----
module pin_filter
    import eeprom_port_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Raw pin.
    input wire logic pin_in,
    // Filtered level and edge pulses.
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } filt_t;

    filt_t r;
    filt_t n;

    // A change counts once the second and third stages agree on it.
    always_comb begin
        n = r;
        n.s1 = pin_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.rise = 1'b0;
        n.fall = 1'b0;
        if (r.s2 == r.s3 && r.s3 != r.level) begin
            n.level = r.s3;
            n.rise = r.s3;
            n.fall = ~r.s3;
        end
    end

    // State register.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, level: PIN_IDLE,
                   rise: 1'b0, fall: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign level_out = r.level;
    assign rise_out = r.rise;
    assign fall_out = r.fall;

endmodule // pin_filter
